// file: design/rioct_defines.vh
// Constants for the second interrupt pin and clock trim block
`ifndef RIOCT_DEFINES_VH
`define RIOCT_DEFINES_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RIOCT_CLK_NS         5
`define RIOCT_PULSE_CYC      21'h17D590   // 7.81 ms in 5 ns cycles
`define RIOCT_DIV_LAST       17'h07FFF
`define RIOCT_SEC_LAST       6'h3B
`define RIOCT_HALF_MIN       6'h1E
`define RIOCT_INT20_LAST     5'h13

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define RIOCT_TRIM_INTERVAL  0
`define RIOCT_ST2_ALARM2_EN  0
`define RIOCT_ST2_MIN_EDGE   1
`define RIOCT_ST2_MIN_PER    2
`define RIOCT_ST2_FREQ_EN    3
`define RIOCT_ST1_ALARM2     2
`define RIOCT_ST1_ALARM1     3
`define RIOCT_ST1_PIN_LEVEL  7
`define RIOCT_TRIM_RESET     8'h00
`define RIOCT_ST2_RESET      8'h00
`define RIOCT_FREQ_RESET     8'h00

`endif

// file: design/rioct_sync.v
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module rioct_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // rioct_sync

// file: design/rioct_trim_div.v
// Crystal divider chain with periodic rate trim and second counters
`timescale 1ns/1ps
`include "rioct_defines.vh"
module rioct_trim_div (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        xtal_rise,
  input  wire [7:0]  clock_rate_trim,
  output reg  [16:0] div,
  output reg  [5:0]  sec_cnt,
  output reg         sec_tick,
  output reg         min_tick
);

  reg  [4:0]  int20_cnt;
  wire [6:0]  step;
  wire        wrap;
  wire        corr_due;
  wire [16:0] start;

  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1) begin : g_rev
      assign step[6-i] = clock_rate_trim[i+1];
    end
  endgenerate

  assign wrap = xtal_rise && (div == `RIOCT_DIV_LAST);

  // correction every 20 or 60 s
  assign corr_due = clock_rate_trim[`RIOCT_TRIM_INTERVAL] ?
                    (sec_cnt == `RIOCT_SEC_LAST) : (int20_cnt == `RIOCT_INT20_LAST);

  // one step is two crystal periods
  assign start = corr_due ? {{9{step[6]}}, step, 1'b0} : 17'h00000;

  always @(posedge clk) begin
    if (!rst_n) begin
      div       <= 17'h00000;
      sec_cnt   <= 6'h00;
      int20_cnt <= 5'h00;
      sec_tick  <= 1'b0;
      min_tick  <= 1'b0;
    end else begin
      sec_tick <= wrap;
      min_tick <= wrap && (sec_cnt == `RIOCT_SEC_LAST);
      if (wrap) begin
        div       <= start;
        sec_cnt   <= (sec_cnt == `RIOCT_SEC_LAST) ? 6'h00 : sec_cnt + 6'h01;
        int20_cnt <= (int20_cnt == `RIOCT_INT20_LAST) ? 5'h00 : int20_cnt + 5'h01;
      end else if (xtal_rise) begin
        div <= div + 17'h00001;
      end
    end
  end

endmodule // rioct_trim_div

// file: design/rioct_top.v
// Second interrupt pin output modes and clock trim register
`timescale 1ns/1ps
`include "rioct_defines.vh"
module rioct_top #(
  parameter [20:0] PULSE_CYC = `RIOCT_PULSE_CYC
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       xtal_32k,
  input  wire       alarm1_match,
  input  wire       alarm2_match,
  input  wire       alarm2_hour_only,
  input  wire       st1_rd,
  input  wire       st2_wr,
  input  wire [7:0] st2_wdata,
  input  wire       freq_wr,
  input  wire [7:0] freq_wdata,
  input  wire       trim_wr,
  input  wire [7:0] trim_wdata,
  input  wire       alarm2_output_pin_i,
  output reg        alarm2_output_pin_o,
  output reg        alarm2_output_pin_oe_n,
  output reg  [7:0] st1_rdata,
  output reg  [7:0] st2_rdata,
  output reg  [7:0] freq_rdata,
  output reg  [7:0] trim_rdata,
  output reg        sec_pulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [1:0] MP_OFF  = 2'b00;
  localparam [1:0] MP_WAIT = 2'b01;
  localparam [1:0] MP_RUN  = 2'b10;

  reg  [7:0]  status2;
  reg  [7:0]  freq_sel;
  reg  [7:0]  clock_rate_trim;
  reg         xtal_q;
  reg         alarm1_q;
  reg         alarm2_q;
  reg         alarm1_flag;
  reg         alarm2_flag;
  reg         alarm2_low;
  reg  [20:0] edge_cnt;
  reg  [1:0]  mp_state;
  reg  [1:0]  next_mp_state;

  wire        xtal_s;
  wire        pin_s;
  wire        xtal_rise;
  wire [16:0] div;
  wire [5:0]  sec_cnt;
  wire        sec_tick;
  wire        min_tick;
  wire        alarm2_enable;
  wire        minute_edge_enable;
  wire        minute_per_enable;
  wire        freq_enable;
  wire        alarm1_fire;
  wire        alarm2_fire;
  wire        edge_low;
  wire        per_low;
  wire        freq_low;
  wire [4:0]  freq_wave;
  wire [4:0]  freq_term;
  wire        pin_low;

  assign alarm2_enable      = status2[`RIOCT_ST2_ALARM2_EN];
  assign minute_edge_enable = status2[`RIOCT_ST2_MIN_EDGE];
  assign minute_per_enable  = status2[`RIOCT_ST2_MIN_PER];
  assign freq_enable        = status2[`RIOCT_ST2_FREQ_EN];

  // ----------------------------------------------------------------
  // Synchronisers and crystal edge
  // ----------------------------------------------------------------
  rioct_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({alarm2_output_pin_i, xtal_32k}),
    .sync_out ({pin_s, xtal_s})
  );

  // Edge detect on synchronised crystal
  always @(posedge clk) begin
    if (!rst_n) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= xtal_s;
    end
  end

  assign xtal_rise = xtal_s && !xtal_q;

  // ----------------------------------------------------------------
  // Divider chain with trim
  // ----------------------------------------------------------------
  rioct_trim_div u_div (
    .clk             (clk),
    .rst_n           (rst_n),
    .xtal_rise       (xtal_rise),
    .clock_rate_trim (clock_rate_trim),
    .div             (div),
    .sec_cnt         (sec_cnt),
    .sec_tick        (sec_tick),
    .min_tick        (min_tick)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Host-written control registers
  always @(posedge clk) begin
    if (!rst_n) begin
      status2         <= `RIOCT_ST2_RESET;
      freq_sel        <= `RIOCT_FREQ_RESET;
      clock_rate_trim <= `RIOCT_TRIM_RESET;
    end else begin
      if (st2_wr) begin
        status2 <= st2_wdata;
      end
      if (freq_wr) begin
        freq_sel <= freq_wdata;
      end
      if (trim_wr) begin
        clock_rate_trim <= trim_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm events
  // ----------------------------------------------------------------
  // Match edges; a match already standing is not an event, except alarm 2 at a minute carry with alarm2_hour_only
  always @(posedge clk) begin
    if (!rst_n) begin
      alarm1_q <= 1'b0;
      alarm2_q <= 1'b0;
    end else begin
      alarm1_q <= alarm1_match;
      alarm2_q <= alarm2_match;
    end
  end

  assign alarm1_fire = alarm1_match && !alarm1_q;

  assign alarm2_fire = alarm2_enable &&
                       ((alarm2_match && !alarm2_q) ||
                        (alarm2_hour_only && alarm2_match && min_tick));

  // Sticky flags; a new event wins over the read clear
  always @(posedge clk) begin
    if (!rst_n) begin
      alarm1_flag <= 1'b0;
      alarm2_flag <= 1'b0;
    end else begin
      if (alarm1_fire) begin
        alarm1_flag <= 1'b1;
      end else if (st1_rd) begin
        alarm1_flag <= 1'b0;
      end
      if (alarm2_fire) begin
        alarm2_flag <= 1'b1;
      end else if (st1_rd) begin
        alarm2_flag <= 1'b0;
      end
    end
  end

  // Alarm 2 pin hold
  always @(posedge clk) begin
    if (!rst_n) begin
      alarm2_low <= 1'b0;
    end else if (!alarm2_enable) begin
      alarm2_low <= 1'b0;
    end else if (alarm2_fire) begin
      alarm2_low <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-minute edge pulse
  // ----------------------------------------------------------------
  // Pulse timer, started at a minute carry while enabled
  always @(posedge clk) begin
    if (!rst_n) begin
      edge_cnt <= 21'h000000;
    end else if (min_tick && minute_edge_enable) begin
      edge_cnt <= PULSE_CYC;
    end else if (edge_cnt != 21'h000000) begin
      edge_cnt <= edge_cnt - 21'h000001;
    end
  end

  // disable masks pulse, re-enable restores it
  assign edge_low = minute_edge_enable && (edge_cnt != 21'h000000);

  // ----------------------------------------------------------------
  // Minute-periodical clock
  // ----------------------------------------------------------------
  // Next state of periodic output
  always @* begin
    next_mp_state = mp_state;
    case (mp_state)
      MP_OFF: begin
        if (minute_per_enable) begin
          next_mp_state = MP_WAIT;
        end
      end
      MP_WAIT: begin
        if (!minute_per_enable) begin
          next_mp_state = MP_OFF;
        end else if (min_tick) begin
          next_mp_state = MP_RUN;
        end
      end
      MP_RUN: begin
        if (min_tick && !minute_per_enable) begin
          next_mp_state = MP_OFF;
        end
      end
      default: begin
        next_mp_state = MP_OFF;
      end
    endcase
  end

  // State register
  always @(posedge clk) begin
    if (!rst_n) begin
      mp_state <= MP_OFF;
    end else begin
      mp_state <= next_mp_state;
    end
  end

  // low for first 30 s of each minute
  // enable gates the low phase directly
  assign per_low = minute_per_enable && (mp_state == MP_RUN) &&
                   (sec_cnt < `RIOCT_HALF_MIN);

  // ----------------------------------------------------------------
  // User-set frequency
  // ----------------------------------------------------------------
  // Sources 1, 2, 4, 8 and 16 Hz from the divider
  assign freq_wave = {div[10], div[11], div[12], div[13], div[14]};

  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1) begin : g_freq
      assign freq_term[k] = !freq_sel[k] || freq_wave[k];
    end
  endgenerate

  assign freq_low = freq_enable && !(&freq_term);

  // ----------------------------------------------------------------
  // Pin and read data
  // ----------------------------------------------------------------
  // any active source pulls low, else released
  assign pin_low = alarm2_low || edge_low || per_low || freq_low;

  // Registered outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      alarm2_output_pin_o    <= 1'b0;
      alarm2_output_pin_oe_n <= 1'b1;
      st1_rdata              <= 8'h00;
      st2_rdata              <= `RIOCT_ST2_RESET;
      freq_rdata             <= `RIOCT_FREQ_RESET;
      trim_rdata             <= `RIOCT_TRIM_RESET;
      sec_pulse              <= 1'b0;
    end else begin
      alarm2_output_pin_o    <= 1'b0;        // Open drain, drives low only
      alarm2_output_pin_oe_n <= !pin_low;
      st1_rdata              <= 8'h00;
      st1_rdata[`RIOCT_ST1_ALARM1]    <= alarm1_flag;
      st1_rdata[`RIOCT_ST1_ALARM2]    <= alarm2_flag;
      st1_rdata[`RIOCT_ST1_PIN_LEVEL] <= pin_s;
      st2_rdata              <= status2;
      freq_rdata             <= freq_sel;
      trim_rdata             <= clock_rate_trim;
      sec_pulse              <= sec_tick;
    end
  end

endmodule // rioct_top

// file: tb/rioct_props.sv
// Checker for the second interrupt pin and clock trim block
`timescale 1ns/1ps
module rioct_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       alarm1_match,
  input wire logic       alarm2_match,
  input wire logic       st1_rd,
  input wire logic       st2_wr,
  input wire logic [7:0] st2_wdata,
  input wire logic       trim_wr,
  input wire logic [7:0] trim_wdata,
  input wire logic       alarm2_output_pin_oe_n,
  input wire logic [7:0] st1_rdata,
  input wire logic [7:0] st2_rdata,
  input wire logic [7:0] trim_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_A2_PIN: assert property ($rose(alarm2_match) && st2_rdata == 8'h01
    |-> ##2 !alarm2_output_pin_oe_n) else $error("alarm2 pin not low");
  AST_A2_FLAG: assert property ($rose(alarm2_match) && st2_rdata == 8'h01
    |-> ##2 st1_rdata[2]) else $error("alarm2 flag not set");
  AST_A2_OFF: assert property (st2_wr && st2_wdata == 8'h00
    |-> ##3 alarm2_output_pin_oe_n) else $error("pin not released");
  AST_A2_HOLD: assert property (!alarm2_output_pin_oe_n && st2_rdata == 8'h01
    && !st2_wr && !$past(st2_wr) |=> !alarm2_output_pin_oe_n) else $error("pin let go");
  AST_RD_CLR: assert property (st1_rd && !$rose(alarm1_match) && !$rose(alarm2_match)
    ##1 !$rose(alarm1_match) && !$rose(alarm2_match) |-> ##1 st1_rdata[3:2] == 2'b00)
    else $error("flags not cleared by read");
  AST_A1_FLAG: assert property ($rose(alarm1_match) |-> ##2 st1_rdata[3])
    else $error("alarm1 flag not set");
  AST_REARM: assert property (st2_wr && st2_wdata == 8'h01 && alarm2_match
    && !$rose(alarm2_match) && alarm2_output_pin_oe_n ##1 alarm2_match [*3]
    |-> alarm2_output_pin_oe_n)
    else $error("standing match fired");
  AST_IDLE: assert property (st2_rdata == 8'h00 && $past(st2_rdata) == 8'h00
    && $past(st2_rdata, 2) == 8'h00 |-> alarm2_output_pin_oe_n) else $error("idle pin low");
  AST_TRIM: assert property (trim_wr ##1 !trim_wr
    |-> ##1 trim_rdata == $past(trim_wdata, 2)) else $error("trim readback wrong");
endmodule // rioct_props

bind rioct_top rioct_props u_rioct_props (.clk, .rst_n, .alarm1_match, .alarm2_match,
  .st1_rd, .st2_wr, .st2_wdata, .trim_wr, .trim_wdata, .alarm2_output_pin_oe_n,
  .st1_rdata, .st2_rdata, .trim_rdata);

// file: tb/rioct_partner.sv
// Far-side model: crystal source and pulled-up interrupt pin
`timescale 1ns/1ps
module rioct_partner (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output logic      xtal,
  output wire logic pin
);
  // Pull-up holds the pin high when released
  assign pin = pin_oe_n ? 1'b1 : pin_o;

  // Sped-up crystal, one rising edge every 2 clocks
  initial begin
    xtal = 1'b0;
    forever begin
      repeat (1) @(posedge clk);
      #1 xtal = ~xtal;
    end
  end
endmodule // rioct_partner

// file: tb/rioct_tb_top.sv
// Testbench for the second interrupt pin and clock trim block
`timescale 1ns/1ps
`include "rioct_defines.vh"
module rioct_tb_top;
  logic       clk, rst_n, a1, a2, rd, s2w, fw, tw, xtal, pin;
  logic [7:0] s2d, fd, td;
  logic [7:0] tv [5] = '{8'hFC, 8'hFE, 8'hFD, 8'h03, 8'h00};
  wire        oe_n, po, sp;
  wire  [7:0] r1, r2, rf, rt;
  int         err_count = 0;
  int         compares = 0;
  int         n;
  int         ticks = 0;

  rioct_top #(.PULSE_CYC(21'h000032)) u_rioct_top (.clk(clk), .rst_n(rst_n), .xtal_32k(xtal),
    .alarm1_match(a1), .alarm2_match(a2), .alarm2_hour_only(1'b0), .st1_rd(rd),
    .st2_wr(s2w), .st2_wdata(s2d), .freq_wr(fw), .freq_wdata(fd), .trim_wr(tw),
    .trim_wdata(td), .alarm2_output_pin_i(pin), .alarm2_output_pin_o(po),
    .alarm2_output_pin_oe_n(oe_n), .st1_rdata(r1), .st2_rdata(r2), .freq_rdata(rf),
    .trim_rdata(rt), .sec_pulse(sp));
  rioct_partner u_rioct_partner (.clk(clk), .pin_o(po), .pin_oe_n(oe_n), .xtal(xtal),
    .pin(pin));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Clock edges since reset release
  always @(posedge clk) begin
    if (rst_n) ticks <= ticks + 1;
  end

  task automatic chk1(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // Wait then step past the edge updates
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One write strobe: bit0 status2, bit1 freq, bit2 trim
  task automatic wreg(logic [2:0] sel, logic [7:0] d);
    @(posedge clk);
    s2w <= sel[0];
    fw <= sel[1];
    tw <= sel[2];
    s2d <= d;
    fd <= d;
    td <= d;
    @(posedge clk);
    s2w <= 1'b0;
    fw <= 1'b0;
    tw <= 1'b0;
  endtask

  task automatic rd1;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Let the pin settle, then count low cycles away from the edges
  task automatic lowcnt;
    cyc(2);
    n = 0;
    repeat (16384) begin
      cyc(1);
      if (oe_n === 1'b0) n++;
    end
  endtask

  task automatic t_reset;
    #1;
    chk1("idle pin", 1'b1, oe_n);
    chk1("pin drive", 1'b0, po);
    chk8("trim", `RIOCT_TRIM_RESET, rt);
    chk8("status2", `RIOCT_ST2_RESET, r2);
    chk8("status1", 8'h80, r1);
  endtask

  task automatic t_alarm2;
    wreg(3'h1, 8'h01);
    cyc(3);
    @(posedge clk) a2 <= 1'b1;
    cyc(6);
    chk1("a2 pin", 1'b0, oe_n);
    chk1("a2 flag", 1'b1, r1[2]);
    chk1("pin level", 1'b0, r1[7]);
    rd1;
    cyc(3);
    chk1("a2 flag rd", 1'b0, r1[2]);
    chk1("a2 pin rd", 1'b0, oe_n);
    wreg(3'h1, 8'h00);
    cyc(3);
    chk1("a2 off", 1'b1, oe_n);
    wreg(3'h1, 8'h01);
    cyc(6);
    chk1("rearm pin", 1'b1, oe_n);
    chk1("rearm flag", 1'b0, r1[2]);
    @(posedge clk) a2 <= 1'b0;
    wreg(3'h1, 8'h00);
  endtask

  task automatic t_alarm1;
    @(posedge clk) a1 <= 1'b1;
    cyc(3);
    chk1("a1 flag", 1'b1, r1[3]);
    rd1;
    cyc(3);
    chk1("a1 flag rd", 1'b0, r1[3]);
    @(posedge clk) a1 <= 1'b0;
  endtask

  task automatic t_trim;
    foreach (tv[i]) begin
      wreg(3'h4, tv[i]);
      cyc(2);
      chk8("trim", tv[i], rt);
    end
  endtask

  task automatic t_freq;
    wreg(3'h2, 8'h10);
    wreg(3'h1, 8'h08);
    lowcnt;
    chk1("16Hz duty", 1'b1, n > 7000 && n < 9400);
    chk8("freq sel", 8'h10, rf);
    wreg(3'h2, 8'h18);
    lowcnt;
    chk1("AND duty", 1'b1, n > 11000 && n < 13500);
    wreg(3'h2, 8'h00);
    lowcnt;
    chk1("none high", 1'b1, n == 0);
    wreg(3'h1, 8'h00);
  endtask

  // First second: 32768 crystal rises of two clocks each, zero trim
  task automatic t_second;
    while (sp !== 1'b1 && ticks < 70000) cyc(1);
    chk1("sec len", 1'b1, ticks >= 65536 && ticks <= 65542);
    cyc(1);
    chk1("sec pulse end", 1'b0, sp);
  endtask

  task automatic wrap_up;
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(80000 * 5);
    err_count++;
    wrap_up;
  end

  // Main sequence
  initial begin
    {rst_n, a1, a2, rd, s2w, fw, tw} = '0;
    {s2d, fd, td} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    t_reset;
    t_alarm2;
    t_alarm1;
    t_trim;
    t_freq;
    t_second;
    wrap_up;
  end
endmodule // rioct_tb_top
